// ### rtl/rdac_params.svh
// Constants for the reference converter control block
// Assumes inclusion by bare name from rtl files
`ifndef RDAC_PARAMS_SVH
`define RDAC_PARAMS_SVH
// Register byte offsets
`define RDAC_CTRL_FIRST_OFS 4'h0
`define RDAC_CTRL_SECOND_OFS 4'h4
`define RDAC_PIN_STATUS_OFS 4'h8
// Field positions in the first control register
`define RDAC_EN_BIT 7
`define RDAC_OE_BIT 5
`define RDAC_PSS_LSB 2
`define RDAC_NSS_BIT 0
// Writable bit masks and reset values
`define RDAC_FIRST_MASK 8'had
`define RDAC_SECOND_MASK 8'h1f
`define RDAC_FIRST_RST 8'h00
`define RDAC_SECOND_RST 8'h00
// Level code width and tap count
`define RDAC_CODE_W 5
`define RDAC_TAPS 32
// AXI responses
`define RDAC_RESP_OKAY 2'b00
`define RDAC_RESP_SLVERR 2'b10
`endif

// ### rtl/rdac_pkg.sv
// Types for the reference converter control block
// Assumes nothing beyond the params header
package rdac_pkg;
  // Upper ladder end sources
  typedef enum logic [1:0] {RDAC_UP_SUPPLY = 2'h0, RDAC_UP_REFPIN = 2'h1, RDAC_UP_FIXED = 2'h2,
    RDAC_UP_RESVD = 2'h3} rdac_upper_t;
  // Lower ladder end sources
  typedef enum logic {RDAC_LO_GROUND = 1'h0, RDAC_LO_REFPIN = 1'h1} rdac_lower_t;
endpackage

// ### rtl/rdac_tap_decode.sv
// One-hot ladder tap selector for the converter
// Assumes code and enable arrive from registers
`timescale 1ns/1ps
`default_nettype none
`include "rdac_params.svh"
module rdac_tap_decode
(
  // Control
  input wire logic enable,
  input wire logic [4:0] code,
  // Ladder switches
  output logic [31:0] tap_select
);
  // One switch closed per code while enabled
  genvar i;
  generate
    for (i = 0; i < `RDAC_TAPS; i++)
    begin : g_tap
      assign tap_select[i] = enable && (code == 5'(i));
    end
  endgenerate
endmodule // rdac_tap_decode
`default_nettype wire

// ### rtl/rdac_ctrl.sv
// Control logic for a 5-bit ratiometric reference converter with AXI4-Lite registers
// Assumes one 250 MHz clock, synchronous active-low reset, analogue ladder outside
// Contract
// [R1] Converter runs only while enabled
// [R2] Five-bit code picks one of 32 levels
// [R3] Level is lower plus span times code/32
// [R4] Upper and lower ladder ends are selectable
// [R5] Result feeds comparator, ADC channel, pin
// [R6] Pin enable connects result to pin
// [R7] Pin enable kills driver and input detector
// [R8] Pin enable kills pull-up and current drive
// [R9] Pin digital read returns zero when routed
// [R10] Source select encodings as documented
// [R11] Reset disables, unroutes, clears code
// [R12] Keeps running in sleep, settings kept
// [R13] Written selection applies next clock edge
`timescale 1ns/1ps
`default_nettype none
`include "rdac_params.svh"
module rdac_ctrl
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Ladder control
  output logic converter_enable,
  output logic [31:0] tap_select,
  output rdac_pkg::rdac_upper_t upper_source_select,
  output rdac_pkg::rdac_lower_t lower_source_select,
  // Routing of the result
  output logic route_to_comparator,
  output logic route_to_adc,
  output logic converter_pin_output_enable,
  // Output pin pad controls
  input wire logic pin_in_raw,
  input wire logic pin_out_en_n_req,
  input wire logic pin_pullup_req,
  input wire logic pin_ccdrive_req,
  output logic pin_out_en_n,
  output logic pin_in_detect_en,
  output logic pin_pullup_en,
  output logic pin_ccdrive_en,
  output logic pin_in_value
);
  import rdac_pkg::*;

  // Whole module state
  typedef struct packed {
    logic [7:0] first;
    logic [7:0] second;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } rdac_state_t;

  rdac_state_t st_reg;
  rdac_state_t st_next;
  logic wr_go;
  logic rd_go;
  logic pin_routed;

  // Write taken when address and data both present and no response pending
  assign wr_go = s_axi_awvalid && s_axi_wvalid && !st_reg.bvalid;
  assign rd_go = s_axi_arvalid && !st_reg.rvalid;
  assign s_axi_awready = wr_go;
  assign s_axi_wready = wr_go;
  assign s_axi_arready = rd_go;
  assign s_axi_bvalid = st_reg.bvalid;
  assign s_axi_bresp = st_reg.bresp;
  assign s_axi_rvalid = st_reg.rvalid;
  assign s_axi_rresp = st_reg.rresp;
  assign s_axi_rdata = st_reg.rdata;

  // Next state: register writes, responses and read data
  always_comb
  begin
    st_next = st_reg;
    if (st_reg.bvalid && s_axi_bready)
      st_next.bvalid = 1'b0;
    if (st_reg.rvalid && s_axi_rready)
      st_next.rvalid = 1'b0;
    if (wr_go)
    begin
      st_next.bvalid = 1'b1;
      st_next.bresp = `RDAC_RESP_OKAY;
      unique case (s_axi_awaddr)
        `RDAC_CTRL_FIRST_OFS:
          if (s_axi_wstrb[0])
            st_next.first = s_axi_wdata[7:0] & `RDAC_FIRST_MASK; // [R13]
        `RDAC_CTRL_SECOND_OFS:
          if (s_axi_wstrb[0])
            st_next.second = s_axi_wdata[7:0] & `RDAC_SECOND_MASK; // [R13]
        `RDAC_PIN_STATUS_OFS: ;
        default: st_next.bresp = `RDAC_RESP_SLVERR;
      endcase
    end
    if (rd_go)
    begin
      st_next.rvalid = 1'b1;
      st_next.rresp = `RDAC_RESP_OKAY;
      st_next.rdata = 32'h0;
      unique case (s_axi_araddr)
        `RDAC_CTRL_FIRST_OFS: st_next.rdata = {24'h0, st_reg.first};
        `RDAC_CTRL_SECOND_OFS: st_next.rdata = {24'h0, st_reg.second};
        `RDAC_PIN_STATUS_OFS: st_next.rdata = {30'h0, pin_routed, pin_in_value}; // [R9]
        default: st_next.rresp = `RDAC_RESP_SLVERR;
      endcase
    end
  end

  // State register; no sleep input, so settings persist across sleep
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_reg.first <= `RDAC_FIRST_RST; // [R11]
      st_reg.second <= `RDAC_SECOND_RST; // [R11]
      st_reg.bvalid <= 1'b0;
      st_reg.bresp <= `RDAC_RESP_OKAY;
      st_reg.rvalid <= 1'b0;
      st_reg.rresp <= `RDAC_RESP_OKAY;
      st_reg.rdata <= 32'h0;
    end
    else
      st_reg <= st_next; // [R12]
  end

  // Converter controls from registers
  assign converter_enable = st_reg.first[`RDAC_EN_BIT]; // [R1]
  assign upper_source_select = rdac_upper_t'(st_reg.first[`RDAC_PSS_LSB +: 2]); // [R4] [R10]
  assign lower_source_select = rdac_lower_t'(st_reg.first[`RDAC_NSS_BIT]); // [R4] [R10]
  assign pin_routed = st_reg.first[`RDAC_OE_BIT];

  // Result routing to consumers
  assign route_to_comparator = converter_enable; // [R5]
  assign route_to_adc = converter_enable; // [R5]
  assign converter_pin_output_enable = pin_routed; // [R6]

  // Pad overrides while routed to the pin
  assign pin_out_en_n = pin_routed ? 1'b1 : pin_out_en_n_req; // [R7]
  assign pin_in_detect_en = !pin_routed; // [R7]
  assign pin_pullup_en = pin_pullup_req && !pin_routed; // [R8]
  assign pin_ccdrive_en = pin_ccdrive_req && !pin_routed; // [R8]
  assign pin_in_value = pin_in_raw && !pin_routed; // [R9]

  // Ladder tap decode, ratiometric level set by tap index
  rdac_tap_decode u_tap
  (
    .enable(converter_enable), // [R1]
    .code(st_reg.second[`RDAC_CODE_W-1:0]), // [R2] [R3]
    .tap_select(tap_select)
  );

  // Checks
  sequence s_write_first;
    wr_go && s_axi_awaddr == `RDAC_CTRL_FIRST_OFS && s_axi_wstrb[0];
  endsequence
  sequence s_write_second;
    wr_go && s_axi_awaddr == `RDAC_CTRL_SECOND_OFS && s_axi_wstrb[0];
  endsequence
  sequence s_resp_waiting;
    s_axi_bvalid && !s_axi_bready;
  endsequence
  sequence s_data_waiting;
    s_axi_rvalid && !s_axi_rready;
  endsequence

  a_enable_follows: assert property (@(posedge aclk) disable iff (!aresetn) // [R1]
    s_write_first |=> converter_enable == $past(s_axi_wdata[7])) else $error("enable mismatch");
  a_tap_onehot: assert property (@(posedge aclk) disable iff (!aresetn) // [R2]
    converter_enable |-> tap_select == (32'h1 << st_reg.second[4:0])) else $error("tap not one-hot");
  a_tap_off: assert property (@(posedge aclk) disable iff (!aresetn) // [R1]
    !converter_enable |-> tap_select == 32'h0) else $error("tap active while disabled");
  a_code_next_edge: assert property (@(posedge aclk) disable iff (!aresetn) // [R13]
    s_write_second ##1 converter_enable |-> tap_select[$past(s_axi_wdata[4:0])]) else $error("code late");
  a_pin_drive_off: assert property (@(posedge aclk) disable iff (!aresetn) // [R7]
    pin_routed |-> pin_out_en_n && !pin_in_detect_en) else $error("pin driver on");
  a_pin_pull_off: assert property (@(posedge aclk) disable iff (!aresetn) // [R8]
    pin_routed |-> !pin_pullup_en && !pin_ccdrive_en) else $error("pull-up on");
  a_pin_read_zero: assert property (@(posedge aclk) disable iff (!aresetn) // [R9]
    pin_routed |-> !pin_in_value) else $error("pin read not zero");
  a_route_pin: assert property (@(posedge aclk) disable iff (!aresetn) // [R6]
    s_write_first |=> converter_pin_output_enable == $past(s_axi_wdata[5])) else $error("route wrong");
  a_upper_sel: assert property (@(posedge aclk) disable iff (!aresetn) // [R10]
    s_write_first |=> upper_source_select == $past(s_axi_wdata[3:2])) else $error("upper select");
  a_reset_clear: assert property (@(posedge aclk) // [R11]
    !aresetn |=> !converter_enable && !pin_routed && st_reg.second == 8'h0) else $error("reset state");
  a_lower_sel: assert property (@(posedge aclk) disable iff (!aresetn) // [R10]
    s_write_first |=> lower_source_select == $past(s_axi_wdata[0])) else $error("lower select");
  a_route_consumers: assert property (@(posedge aclk) disable iff (!aresetn) // [R5]
    route_to_comparator == converter_enable && route_to_adc == converter_enable) else $error("consumer routing");
  a_pin_free: assert property (@(posedge aclk) disable iff (!aresetn) // [R7]
    !pin_routed |-> pin_out_en_n == pin_out_en_n_req && pin_in_detect_en) else $error("pad forced while free");
  a_first_hold: assert property (@(posedge aclk) disable iff (!aresetn) // [R12]
    !s_write_first |=> $stable(st_reg.first)) else $error("settings drifted");

  // Write answers come the edge after acceptance; answers stand until the master takes them
  a_write_answer: assert property (@(posedge aclk) disable iff (!aresetn) // [R13]
    wr_go |=> s_axi_bvalid) else $error("write answer missing");
  a_resp_hold: assert property (@(posedge aclk) disable iff (!aresetn) // [R13]
    s_resp_waiting |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
  a_read_hold: assert property (@(posedge aclk) disable iff (!aresetn) // [R13]
    s_data_waiting |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
endmodule // rdac_ctrl
`default_nettype wire

// ### tb/rdac_pin_model.sv
// Pad model for the converter output pin
// Assumes the control block gates the pad enables
`timescale 1ns/1ps
`default_nettype none
module rdac_pin_model
(
  // Clock
  input wire logic aclk,
  // Pad input level
  output logic pin_in_raw
);
  // Level flips every cycle so a stale read shows
  initial pin_in_raw = 1'b0;
  always @(posedge aclk) pin_in_raw <= ~pin_in_raw;
endmodule // rdac_pin_model
`default_nettype wire

// ### tb/ref_dac_control_tb_top.sv
// Bench for the converter control block
// Assumes the rtl files and package are compiled first
`timescale 1ns/1ps
`default_nettype none
`include "rdac_params.svh"
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_errors++; \
  $display("mismatch %0t got %0h want %0h", $time, a, b); end end
module ref_dac_control_tb_top;
  import rdac_pkg::*;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic pin_out_en_n_req, pin_pullup_req, pin_ccdrive_req, pin_in_raw, pin_seen;
  logic [3:0] s_axi_awaddr, s_axi_wstrb, s_axi_araddr, a;
  logic [31:0] s_axi_wdata, s_axi_rdata, tap_select, d, e;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, converter_enable;
  rdac_upper_t upper_source_select;
  rdac_lower_t lower_source_select;
  logic route_to_comparator, route_to_adc, converter_pin_output_enable;
  logic pin_out_en_n, pin_in_detect_en, pin_pullup_en, pin_ccdrive_en, pin_in_value;
  int n_errors = 0, tests_run = 0, seed = 32'h0cda1c24, cyc = 0, mf, ms;
  // Design and pad model
  rdac_ctrl dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .converter_enable, .tap_select, .upper_source_select, .lower_source_select,
    .route_to_comparator, .route_to_adc, .converter_pin_output_enable, .pin_in_raw,
    .pin_out_en_n_req, .pin_pullup_req, .pin_ccdrive_req, .pin_out_en_n, .pin_in_detect_en,
    .pin_pullup_en, .pin_ccdrive_en, .pin_in_value);
  rdac_pin_model pad (.aclk(aclk), .pin_in_raw(pin_in_raw));
  // Clock and cycle limit
  initial
  begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  always @(posedge aclk)
  begin
    cyc++;
    {pin_out_en_n_req, pin_pullup_req, pin_ccdrive_req} <= 3'($random(seed));
    if (cyc == 5000)
    begin
      n_errors++;
      wrap_up();
    end
  end
  // AXI write and model update
  task automatic wr(input logic [3:0] wa, input logic [31:0] wd, input logic [3:0] ws);
    s_axi_awaddr <= wa;
    s_axi_wdata <= wd;
    s_axi_wstrb <= ws;
    {s_axi_awvalid, s_axi_wvalid} <= 2'h3;
    do @(posedge aclk); while (!(s_axi_awready && s_axi_wready));
    {s_axi_awvalid, s_axi_wvalid} <= 2'h0;
    // Random delay before accepting the answer
    repeat (2'($random(seed))) @(posedge aclk);
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    `CHK(r, (wa == 4'hc) ? `RDAC_RESP_SLVERR : `RDAC_RESP_OKAY)
    if (ws[0] && wa == 4'h0) mf = wd[7:0] & `RDAC_FIRST_MASK;
    if (ws[0] && wa == 4'h4) ms = wd[7:0] & `RDAC_SECOND_MASK;
  endtask
  // AXI read against the model
  task automatic rd(input logic [3:0] ra);
    s_axi_araddr <= ra;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    pin_seen = pin_in_raw; // Pad level at the taking edge
    s_axi_arvalid <= 1'b0;
    repeat (2'($random(seed))) @(posedge aclk);
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    e = (ra == 4'h0) ? mf : (ra == 4'h4) ? ms : (ra == 4'h8) ? {mf[5], pin_seen & !mf[5]} : 32'h0;
    `CHK(d[31:1], e[31:1])
    `CHK(d[0], e[0])
    `CHK(r, (ra == 4'hc) ? `RDAC_RESP_SLVERR : `RDAC_RESP_OKAY)
  endtask
  // Port outputs against the model
  task automatic chk();
    @(negedge aclk);
    `CHK(converter_enable, mf[7])
    `CHK(tap_select, mf[7] ? 32'h1 << ms[4:0] : 32'h0)
    `CHK(upper_source_select, mf[3:2])
    `CHK(lower_source_select, mf[0])
    `CHK({route_to_comparator, route_to_adc}, {2{mf[7]}})
    `CHK(converter_pin_output_enable, mf[5])
    `CHK(pin_out_en_n, mf[5] | pin_out_en_n_req)
    `CHK(pin_in_detect_en, !mf[5])
    `CHK({pin_pullup_en, pin_ccdrive_en}, {pin_pullup_req, pin_ccdrive_req} & {2{!mf[5]}})
    `CHK(pin_in_value, pin_in_raw & !mf[5])
    @(posedge aclk);
  endtask
  // Verdict and end of run
  task wrap_up();
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h0;
    {s_axi_awaddr, s_axi_wstrb, s_axi_araddr, s_axi_wdata} = 44'h0;
    {pin_out_en_n_req, pin_pullup_req, pin_ccdrive_req} = 3'h0;
    mf = 0;
    ms = 0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    chk();
    for (int k = 0; k < 4; k++)
    begin
      wr(4'h0, {24'h0, 4'ha, k[1:0], 1'b0, k[0]}, 4'h1);
      wr(4'h4, {27'h0, {5{k[0]}}}, 4'h1);
      chk();
    end
    for (int k = 0; k < 60; k++)
    begin
      a = {2'($random(seed)), 2'b00};
      wr(a, $random(seed), 4'($random(seed)));
      chk();
      rd({2'($random(seed)), 2'b00});
    end
    repeat (30) @(posedge aclk);
    chk();
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    mf = 0;
    ms = 0;
    chk();
    rd(4'h4);
    wrap_up();
  end
endmodule // ref_dac_control_tb_top
`default_nettype wire
